// File: uxr_pkg.sv
package uxr_pkg;

    // Byte addresses of the word-aligned APB registers
    localparam logic [7:0] ADDR_SELECTOR  = 8'h00;
    localparam logic [7:0] ADDR_SCRATCH   = 8'h04;
    localparam logic [7:0] ADDR_DIV_LOW   = 8'h08;
    localparam logic [7:0] ADDR_DIV_HIGH  = 8'h0c;
    localparam logic [7:0] ADDR_EFC       = 8'h10;
    localparam logic [7:0] ADDR_IER       = 8'h14;
    localparam logic [7:0] ADDR_FCR       = 8'h18;
    localparam logic [7:0] ADDR_MCR       = 8'h1c;
    localparam logic [7:0] ADDR_TX_FILL   = 8'h20;
    localparam logic [7:0] ADDR_RX_FILL   = 8'h24;
    localparam logic [7:0] ADDR_START1    = 8'h28;
    localparam logic [7:0] ADDR_START2    = 8'h2c;
    localparam logic [7:0] ADDR_STOP1     = 8'h30;
    localparam logic [7:0] ADDR_STOP2     = 8'h34;
    localparam logic [7:0] ADDR_RX_TRIG   = 8'h38;
    localparam logic [7:0] ADDR_STATUS    = 8'h3c;

    // Selector fields
    localparam int SEL_CNT_BIT  = 0;
    localparam int SEL_SET_LSB  = 1;
    localparam logic [1:0] SET_GENERAL = 2'h0;
    localparam logic [1:0] SET_FIRST   = 2'h1;
    localparam logic [1:0] SET_SECOND  = 2'h2;

    // Enhanced feature register fields
    localparam int EFC_AUTO_CTS  = 7;
    localparam int EFC_AUTO_RTS  = 6;
    localparam int EFC_SPECIAL   = 5;
    localparam int EFC_ENH_EN    = 4;

    // Bits that only change while the enhanced enable is set, and the MCR RTS bit
    localparam logic [7:0] IER_ENH_MASK = 8'hf0;
    localparam logic [7:0] FCR_ENH_MASK = 8'h30;
    localparam logic [7:0] MCR_ENH_MASK = 8'he0;
    localparam int MCR_RTS_BIT = 1;

    // Values after reset
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_DIVISOR = 16'h0001;
    localparam logic [7:0]  RST_RX_TRIG = 8'h01;

    typedef enum logic [1:0] {
        UXR_IDLE,
        UXR_ACCESS
    } uxr_apb_t;

endpackage

// File: uxr_ctrl.sv
// Functional notes
// RULE1 - see selector is write-only, reads return zero
// RULE2 - see selector bits 2:1 pick register set
// RULE3 - see fill counters readable only when bit0 set
// RULE4 - see set selection overrides counter access bit
// RULE5 - see scratch byte stores and returns host data
// RULE6 - see two bytes form 16-bit baud divisor
// RULE7 - see transmit fill counter readable, read-only
// RULE8 - see receive fill counter readable, read-only
// RULE9 - see auto CTS stops transmitter while high
// RULE10 - see auto RTS with trigger event and hysteresis
// RULE11 - see RTS follows modem control when auto off
// RULE12 - see special char matches second stop, flags
// RULE13 - see char bit0 aligns to received LSB
// RULE14 - see host clears flow bits before detection
// RULE15 - see enhanced bits change only while enabled
// RULE16 - see bits 3:0 select software flow mode
// RULE17 - see dual mode compares two-byte sequence
// RULE18 - see enhanced register clears on reset
// RULE19 - see flow bits decode pairs for tx/rx
// RULE20 - see flow characters never sent as payload
// RULE21 - see baud tick divides clock, zero invalid
// RULE22 - see reserved selector bits and code ignored
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module uxr_ctrl
    import uxr_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // APB slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // FIFO fill levels and receive character stream
    input  wire logic [CNT_W-1:0]  tx_level,
    input  wire logic [CNT_W-1:0]  rx_level,
    input  wire logic              rx_char_valid,
    input  wire logic [7:0]        rx_char,
    // Modem lines, active low
    input  wire logic              cts_n,
    output var  logic              rts_n,
    // Outputs to transmitter, receiver and interrupt logic
    output var  logic              tx_allowed,
    output var  logic              baud_tick,
    output var  logic              divisor_invalid,
    output var  logic              rx_trig_event,
    output var  logic              special_char_hit,
    output var  logic              rx_got_start,
    output var  logic              rx_got_stop,
    output var  logic [1:0]        tx_flow_mode,
    output var  logic [15:0]       tx_start_seq,
    output var  logic [15:0]       tx_stop_seq,
    output var  logic [7:0]        ier_bits,
    output var  logic [7:0]        fcr_bits,
    output var  logic [7:0]        mcr_bits
);

    initial begin
        if (CNT_W < 1 || CNT_W > 8) begin
            $error("CNT_W must be 1 to 8");
        end
    end

    // Merge a write into a register, only the bits set in the mask change
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wr,
                                         input logic [7:0] msk);
        merge = (old & ~msk) | (wr & msk);
    endfunction

    // Bit 0 of the stored character lines up with the received LSB
    function automatic logic hit(input logic [7:0] c,
                                 input logic [7:0] k);
        hit = (c == k);
    endfunction

    // Register state
    logic [7:0]  selector;
    logic [7:0]  scratch;
    logic [15:0] divisor;
    logic [7:0]  efc;
    logic [7:0]  interrupt_enable_reg;
    logic [7:0]  fifo_control_reg;
    logic [7:0]  modem_control_reg;
    logic [7:0]  start1;
    logic [7:0]  start2;
    logic [7:0]  stop1;
    logic [7:0]  stop2;
    logic [7:0]  rx_trig;
    uxr_apb_t    apb_st;
    logic [7:0]  next_selector;
    logic [7:0]  next_scratch;
    logic [15:0] next_divisor;
    logic [7:0]  next_efc;
    logic [7:0]  next_ier;
    logic [7:0]  next_fcr;
    logic [7:0]  next_mcr;
    logic [7:0]  next_start1;
    logic [7:0]  next_start2;
    logic [7:0]  next_stop1;
    logic [7:0]  next_stop2;
    logic [7:0]  next_rx_trig;
    uxr_apb_t    next_apb_st;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    logic [1:0]  reg_set;
    logic        cnt_open;
    logic        wr_go;
    logic [7:0]  wb;
    logic [7:0]  enh_mask_ier;
    logic [7:0]  enh_mask_fcr;
    logic [7:0]  enh_mask_mcr;

    // Reserved code 11 falls back to the general set only
    assign reg_set  = (selector[2:1] == 2'h3) ? SET_GENERAL
                                              : selector[2:1]; // see RULE22
    // Set selection has priority over the counter enable
    assign cnt_open = selector[SEL_CNT_BIT] &&
                      (selector[2:1] == SET_GENERAL); // see RULE3 see RULE4
    assign wr_go    = (apb_st == UXR_ACCESS) && psel && penable && pwrite;
    assign wb       = pwdata[7:0];
    // Enhanced bits are frozen while the enable bit is clear
    assign enh_mask_ier = efc[EFC_ENH_EN] ? 8'hff : ~IER_ENH_MASK; // see RULE15
    assign enh_mask_fcr = efc[EFC_ENH_EN] ? 8'hff : ~FCR_ENH_MASK; // see RULE15
    assign enh_mask_mcr = efc[EFC_ENH_EN] ? 8'hff : ~MCR_ENH_MASK; // see RULE15

    // APB decode: answer is prepared in setup, given in the access cycle
    always_comb begin
        next_selector = selector;
        next_scratch  = scratch;
        next_divisor  = divisor;
        next_efc      = efc;
        next_ier      = interrupt_enable_reg;
        next_fcr      = fifo_control_reg;
        next_mcr      = modem_control_reg;
        next_start1   = start1;
        next_start2   = start2;
        next_stop1    = stop1;
        next_stop2    = stop2;
        next_rx_trig  = rx_trig;
        next_apb_st   = UXR_IDLE;
        next_prdata   = 32'h0000_0000;
        next_pready   = 1'b0;
        next_pslverr  = 1'b0;
        if (apb_st == UXR_IDLE && psel && !penable) begin
            next_apb_st = UXR_ACCESS;
            next_pready = 1'b1;
            if (paddr == ADDR_SELECTOR) begin
                next_prdata = 32'h0000_0000; // see RULE1
            end else if (reg_set == SET_GENERAL && paddr == ADDR_SCRATCH) begin
                next_prdata = {24'h00_0000, scratch}; // see RULE5
            end else if (reg_set == SET_GENERAL && paddr == ADDR_DIV_LOW) begin
                next_prdata = {24'h00_0000, divisor[7:0]};
            end else if (reg_set == SET_GENERAL && paddr == ADDR_DIV_HIGH) begin
                next_prdata = {24'h00_0000, divisor[15:8]};
            end else if (reg_set == SET_GENERAL && paddr == ADDR_IER) begin
                next_prdata = {24'h00_0000, interrupt_enable_reg};
            end else if (reg_set == SET_GENERAL && paddr == ADDR_FCR) begin
                next_prdata = {24'h00_0000, fifo_control_reg};
            end else if (reg_set == SET_GENERAL && paddr == ADDR_MCR) begin
                next_prdata = {24'h00_0000, modem_control_reg};
            end else if (cnt_open && paddr == ADDR_TX_FILL && !pwrite) begin
                next_prdata = {24'h00_0000, 8'(tx_level)}; // see RULE7
            end else if (cnt_open && paddr == ADDR_RX_FILL && !pwrite) begin
                next_prdata = {24'h00_0000, 8'(rx_level)}; // see RULE8
            end else if (reg_set == SET_FIRST && paddr == ADDR_EFC) begin
                next_prdata = {24'h00_0000, efc};
            end else if (reg_set == SET_FIRST && paddr == ADDR_START1) begin
                next_prdata = {24'h00_0000, start1};
            end else if (reg_set == SET_FIRST && paddr == ADDR_START2) begin
                next_prdata = {24'h00_0000, start2};
            end else if (reg_set == SET_FIRST && paddr == ADDR_STOP1) begin
                next_prdata = {24'h00_0000, stop1};
            end else if (reg_set == SET_FIRST && paddr == ADDR_STOP2) begin
                next_prdata = {24'h00_0000, stop2};
            end else if (reg_set == SET_SECOND && paddr == ADDR_RX_TRIG) begin
                next_prdata = {24'h00_0000, rx_trig};
            end else if (reg_set == SET_SECOND && paddr == ADDR_STATUS &&
                         !pwrite) begin
                next_prdata = {29'h0000_0000, rts_n, tx_allowed,
                               divisor_invalid};
            end else begin
                next_pslverr = 1'b1; // see RULE2
            end
        end
        // Writes land at the access edge unless refused in setup
        if (wr_go && !pslverr) begin
            if (paddr == ADDR_SELECTOR) begin
                next_selector = {5'h00, wb[2:0]}; // see RULE1 see RULE22
            end else if (paddr == ADDR_SCRATCH) begin
                next_scratch = wb; // see RULE5
            end else if (paddr == ADDR_DIV_LOW) begin
                next_divisor = {divisor[15:8], wb}; // see RULE6
            end else if (paddr == ADDR_DIV_HIGH) begin
                next_divisor = {wb, divisor[7:0]}; // see RULE6
            end else if (paddr == ADDR_IER) begin
                next_ier = merge(interrupt_enable_reg, wb, enh_mask_ier); // see RULE15
            end else if (paddr == ADDR_FCR) begin
                next_fcr = merge(fifo_control_reg, wb, enh_mask_fcr); // see RULE15
            end else if (paddr == ADDR_MCR) begin
                next_mcr = merge(modem_control_reg, wb, enh_mask_mcr); // see RULE15
            end else if (paddr == ADDR_EFC) begin
                next_efc = wb; // see RULE16
            end else if (paddr == ADDR_START1) begin
                next_start1 = wb;
            end else if (paddr == ADDR_START2) begin
                next_start2 = wb;
            end else if (paddr == ADDR_STOP1) begin
                next_stop1 = wb;
            end else if (paddr == ADDR_STOP2) begin
                next_stop2 = wb;
            end else if (paddr == ADDR_RX_TRIG) begin
                next_rx_trig = wb;
            end
        end
    end

    // Register file and bus answer; all clear on reset except divisor and rx_trig, which load 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            selector <= RST_BYTE;
            scratch  <= RST_BYTE;
            divisor  <= RST_DIVISOR;
            efc      <= RST_BYTE; // see RULE18
            interrupt_enable_reg      <= RST_BYTE;
            fifo_control_reg      <= RST_BYTE;
            modem_control_reg      <= RST_BYTE;
            start1   <= RST_BYTE;
            start2   <= RST_BYTE;
            stop1    <= RST_BYTE;
            stop2    <= RST_BYTE;
            rx_trig  <= RST_RX_TRIG;
            apb_st   <= UXR_IDLE;
            prdata   <= 32'h0000_0000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            selector <= next_selector;
            scratch  <= next_scratch;
            divisor  <= next_divisor;
            efc      <= next_efc;
            interrupt_enable_reg      <= next_ier;
            fifo_control_reg      <= next_fcr;
            modem_control_reg      <= next_mcr;
            start1   <= next_start1;
            start2   <= next_start2;
            stop1    <= next_stop1;
            stop2    <= next_stop2;
            rx_trig  <= next_rx_trig;
            apb_st   <= next_apb_st;
            prdata   <= next_prdata;
            pready   <= next_pready;
            pslverr  <= next_pslverr;
        end
    end

    // Baud generator: one tick every divisor cycles, none for zero
    logic [15:0] baud_cnt;
    logic [15:0] next_baud_cnt;
    logic        next_baud_tick;
    always_comb begin
        next_baud_cnt  = baud_cnt;
        next_baud_tick = 1'b0;
        if (divisor == 16'h0000) begin
            next_baud_cnt = 16'h0000; // see RULE21
        end else if (baud_cnt >= divisor - 16'h0001) begin
            next_baud_cnt  = 16'h0000;
            next_baud_tick = 1'b1; // see RULE21
        end else begin
            next_baud_cnt = baud_cnt + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt        <= 16'h0000;
            baud_tick       <= 1'b0;
            divisor_invalid <= 1'b0;
        end else begin
            baud_cnt        <= next_baud_cnt;
            baud_tick       <= next_baud_tick;
            divisor_invalid <= (divisor == 16'h0000); // see RULE21
        end
    end

    // Hardware flow control; RTS has hysteresis of one level
    logic [7:0] rx_lvl8;
    logic       next_rts_n;
    assign rx_lvl8 = 8'(rx_level);
    always_comb begin
        next_rts_n = rts_n;
        if (!efc[EFC_AUTO_RTS]) begin
            next_rts_n = ~modem_control_reg[MCR_RTS_BIT]; // see RULE11
        end else if (rx_lvl8 > rx_trig) begin
            next_rts_n = 1'b1; // see RULE10
        end else if (rx_lvl8 < rx_trig) begin
            next_rts_n = 1'b0; // see RULE10
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts_n         <= 1'b1;
            tx_allowed    <= 1'b1;
            rx_trig_event <= 1'b0;
        end else begin
            rts_n         <= next_rts_n;
            tx_allowed    <= !(efc[EFC_AUTO_CTS] && cts_n); // see RULE9
            rx_trig_event <= efc[EFC_AUTO_RTS] &&
                             (rx_lvl8 >= rx_trig); // see RULE10
        end
    end

    // Receive character compare; the character always goes on to the FIFO
    logic [7:0] prev_char;
    logic       prev_ok;
    logic       dual;
    logic       next_special;
    logic       next_start;
    logic       next_stop;
    assign dual = (efc[3:0] == 4'hf); // see RULE17 see RULE19
    always_comb begin
        next_special = 1'b0;
        next_start   = 1'b0;
        next_stop    = 1'b0;
        if (rx_char_valid) begin
            next_special = efc[EFC_SPECIAL] && hit(rx_char, stop2); // see RULE12 see RULE13
            if (dual) begin
                next_start = prev_ok && hit(prev_char, start1) &&
                             hit(rx_char, start2); // see RULE17
                next_stop  = prev_ok && hit(prev_char, stop1) &&
                             hit(rx_char, stop2); // see RULE17
            end else begin
                next_start = (efc[1] && hit(rx_char, start1)) ||
                             (efc[0] && hit(rx_char, start2)); // see RULE19
                next_stop  = (efc[1] && hit(rx_char, stop1)) ||
                             (efc[0] && hit(rx_char, stop2)); // see RULE19
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_char        <= 8'h00;
            prev_ok          <= 1'b0;
            special_char_hit <= 1'b0;
            rx_got_start     <= 1'b0;
            rx_got_stop      <= 1'b0;
        end else begin
            if (rx_char_valid) begin
                prev_char <= rx_char;
                prev_ok   <= 1'b1;
            end
            special_char_hit <= next_special;
            rx_got_start     <= next_start;
            rx_got_stop      <= next_stop;
        end
    end

    // Transmit side flow selection and characters for the shifter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_flow_mode <= 2'h0;
            tx_start_seq <= 16'h0000;
            tx_stop_seq  <= 16'h0000;
            ier_bits     <= 8'h00;
            fcr_bits     <= 8'h00;
            mcr_bits     <= 8'h00;
        end else begin
            tx_flow_mode <= {efc[2], efc[3]}; // see RULE16 see RULE19
            tx_start_seq <= {start1, start2}; // see RULE17
            tx_stop_seq  <= {stop1, stop2};
            ier_bits     <= interrupt_enable_reg;
            fcr_bits     <= fifo_control_reg;
            mcr_bits     <= modem_control_reg;
        end
    end

    // Checks
    chk_sel_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && paddr == ADDR_SELECTOR) |-> prdata == 32'h0) // see RULE1
        else $error("selector read returned data");
    chk_cnt_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && !cnt_open && apb_st == UXR_IDLE &&
         (paddr == ADDR_TX_FILL || paddr == ADDR_RX_FILL))
        |=> pslverr) // see RULE3
        else $error("fill counter readable while closed");
    chk_set_priority: assert property (@(posedge pclk) disable iff (!presetn)
        (selector[2:1] != 2'h0) |-> !cnt_open) // see RULE4
        else $error("counters open outside general set");
    chk_scratch_store: assert property (@(posedge pclk) // see RULE5
        disable iff (!presetn)
        (wr_go && !pslverr && paddr == ADDR_SCRATCH) |=> scratch == $past(wb))
        else $error("scratch write lost");
    chk_cts_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (efc[EFC_AUTO_CTS] && cts_n) |=> !tx_allowed) // see RULE9
        else $error("transmit not stopped by CTS");
    chk_rts_manual: assert property (@(posedge pclk) disable iff (!presetn)
        (!efc[EFC_AUTO_RTS]) |=> rts_n == !$past(modem_control_reg[MCR_RTS_BIT])) // see RULE11
        else $error("RTS not following modem control");
    chk_special_hit: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_char_valid && efc[EFC_SPECIAL] && rx_char == stop2)
        |=> special_char_hit) // see RULE12
        else $error("special character missed");
    chk_enh_latch: assert property (@(posedge pclk) disable iff (!presetn)
        !efc[EFC_ENH_EN] && !$past(efc[EFC_ENH_EN])
        |-> (interrupt_enable_reg & IER_ENH_MASK) == ($past(interrupt_enable_reg) & IER_ENH_MASK)) // see RULE15
        else $error("enhanced bits changed while latched");
    chk_baud_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (divisor == 16'h0 && $past(divisor) == 16'h0) |=> !baud_tick
        && divisor_invalid) // see RULE21
        else $error("tick with zero divisor");

endmodule

`default_nettype wire

// File: uxr_peer.sv
`timescale 1ns/10ps
`default_nettype none

// Remote serial device on the modem lines and the receive stream
module uxr_peer (
    // Clock and modem line, active low
    input  wire logic       pclk,
    output var  logic       cts_n = 1'b0,
    // Received characters towards the block
    output var  logic       rx_char_valid = 1'b0,
    output var  logic [7:0] rx_char = 8'h00
);
    // Raises cts_n while the remote cannot accept data
    task automatic hold(input logic h);
        @(posedge pclk) cts_n <= h;
    endtask

    // One character a call; flow bytes only where meant as such
    task automatic send(input logic [7:0] c);
        @(posedge pclk) rx_char_valid <= 1'b1;
        rx_char <= c;
        @(posedge pclk) rx_char_valid <= 1'b0;
        rx_char <= ~c; // Stale byte inverted so it never looks held
    endtask
endmodule

`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
// Counts every compare and reports a mismatch at once
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_count++; $display("ERROR %s exp %h got %h", n, e, g); end end

module tb;
    import uxr_pkg::*;
    // Bench-driven inputs carry values from time zero
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, tx_level = 8'h07, rx_level = 8'h09;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic        pclk, pready, pslverr, rerr, cts_n, rts_n, tx_allowed, hv;
    logic        baud_tick, divisor_invalid, rx_trig_event, rx_char_valid;
    logic        special_char_hit;
    logic [7:0]  rx_char, ier_bits;
    int          err_count, check_count, cyc, n;

    uxr_ctrl uxr_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .tx_level, .rx_level,
        .rx_char_valid, .rx_char, .cts_n, .rts_n, .tx_allowed, .baud_tick,
        .divisor_invalid, .rx_trig_event, .special_char_hit, .rx_got_start(),
        .rx_got_stop(), .tx_flow_mode(), .tx_start_seq(), .tx_stop_seq(),
        .ier_bits, .fcr_bits(), .mcr_bits());
    uxr_peer uxr_peer_i (.pclk, .cts_n, .rx_char_valid, .rx_char);

    // 100 ns clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Cuts a hang short; the whole run needs far fewer cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One APB transfer, held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    // Waits c edges and lets their updates land
    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask

    // Sends one character and gathers the match pulse after it
    task automatic rx(input logic [7:0] c);
        hv = 1'b0;
        uxr_peer_i.send(c);
        repeat (3) @(negedge pclk) hv = hv | special_char_hit;
    endtask

    // Set decode, reserved bits and codes, fill counter gating
    task automatic t_select();
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, ADDR_SELECTOR, 8'hf8 | 8'(s));
            apb(1'b0, ADDR_TX_FILL, 8'h00);
            `CHK("cnt", s != 1, rerr)
            apb(1'b0, ADDR_EFC, 8'h00);
            `CHK("set1", s < 2 || s > 3, rerr)
            apb(1'b0, ADDR_RX_TRIG, 8'h00);
            `CHK("set2", s < 4 || s > 5, rerr)
        end
        apb(1'b1, ADDR_SELECTOR, 8'h01);
        apb(1'b0, ADDR_SELECTOR, 8'h00);
        `CHK("sel_rd", 32'h0, rdata)
        apb(1'b0, ADDR_TX_FILL, 8'h00);
        `CHK("tx_fill", 32'h07, rdata)
        apb(1'b0, ADDR_RX_FILL, 8'h00);
        `CHK("rx_fill", 32'h09, rdata)
        apb(1'b1, ADDR_SELECTOR, 8'h00);
    endtask

    // Scratch byte, divisor bytes and the baud tick rate
    task automatic t_regs();
        apb(1'b1, ADDR_SCRATCH, 8'ha5);
        apb(1'b0, ADDR_SCRATCH, 8'h00);
        `CHK("scratch", 32'ha5, rdata)
        apb(1'b1, ADDR_DIV_LOW, 8'h03);
        wt(6);
        repeat (30) @(negedge pclk) n += int'(baud_tick);
        `CHK("ticks", 10, n)
        apb(1'b1, ADDR_DIV_HIGH, 8'h12);
        apb(1'b0, ADDR_DIV_HIGH, 8'h00);
        `CHK("div_high", 32'h12, rdata)
    endtask

    // Auto CTS gating, RTS hysteresis, then RTS from modem control
    task automatic t_flow();
        apb(1'b1, ADDR_SELECTOR, 8'h04);
        apb(1'b1, ADDR_RX_TRIG, 8'h04);
        apb(1'b1, ADDR_SELECTOR, 8'h02);
        apb(1'b0, ADDR_EFC, 8'h00);
        `CHK("efc_rst", 32'h0, rdata)
        apb(1'b1, ADDR_EFC, 8'hc0);
        uxr_peer_i.hold(1'b1);
        wt(3);
        `CHK("cts_stop", 1'b0, tx_allowed)
        uxr_peer_i.hold(1'b0);
        // Levels 5, 4, 3 around a trigger of 4: high, held, low
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk) rx_level <= 8'(5 - i);
            wt(3);
            `CHK("rts_n", i != 2, rts_n)
            `CHK("trig", i != 2, rx_trig_event)
        end
        `CHK("cts_go", 1'b1, tx_allowed)
        apb(1'b1, ADDR_EFC, 8'h00);
        apb(1'b1, ADDR_SELECTOR, 8'h00);
        @(posedge pclk) rx_level <= 8'h09;
        apb(1'b1, ADDR_MCR, 8'h02);
        wt(2);
        `CHK("rts_mcr", 1'b0, rts_n)
    endtask

    // Enhanced interrupt-enable bits move only while enabled
    task automatic t_latch();
        logic [7:0] ex [3] = '{8'h0f, 8'hff, 8'hf0};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADDR_SELECTOR, 8'h02);
            apb(1'b1, ADDR_EFC, (i == 1) ? 8'h10 : 8'h00);
            apb(1'b1, ADDR_SELECTOR, 8'h00);
            apb(1'b1, ADDR_IER, (i < 2) ? 8'hff : 8'h00);
            wt(1); // Copy of the register lags it by one edge
            `CHK("ier", ex[i], ier_bits)
        end
    endtask

    // Special character on the second stop byte, and its bit order
    task automatic t_special();
        apb(1'b1, ADDR_SELECTOR, 8'h02);
        apb(1'b1, ADDR_STOP2, 8'h01);
        apb(1'b1, ADDR_EFC, 8'h20); // Flow bits left clear
        rx(8'h01);
        `CHK("special", 1'b1, hv)
        rx(8'h80);
        `CHK("lsb", 1'b0, hv)
    endtask

    // Reset for three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_select();
        t_regs();
        t_flow();
        t_latch();
        t_special();
        final_report();
    end
endmodule

`default_nettype wire
